//--- hdl/sbes_top.sv
// Status byte, service request and standard event summary logic
`timescale 1ns/1ps
//
// Function
// - Status bit 0 set whenever any failure group bit is latched.
// - Status bit 3 follows the signal quality group summary.
// - Status bit 4 stays set while the output queue holds unread messages.
// - Status bit 5 set when an enabled standard event bit is set.
// - Serial poll shows bit 6 as request-service, equal to the request line.
// - Status query shows bit 6 as master summary; reading never clears it.
// - Status bit 7 follows the operation group summary.
// - Status bits 1 and 2 carry nothing.
// - Serial poll and status query return the same byte.
// - Host writes 8-bit request mask; enabled set summary raises request.
// - Standard events latch every true state; no condition or filter.
// - Event bits: 0 done, 2 query, 3 device, 4 exec, 5 command, 7 power.
// - Operation-complete set after the command once nothing is pending.
// - Query error on empty-queue read or lost output data.
// - Device error bit set on any internal error.
// - Execution error bit set when a command cannot be carried out.
// - Command error bit set on a malformed program message.
// - Power-on bit set on every power-up.
// - Event query returns the event register, then clears it.
// - Clear command empties the event register without answering.
// - Host writes 16-bit event mask; enabled events set bit 5.
// - Failures latch with no enable, drive bit 0, never clear.
module sbes_top
    import sbes_pkg::*;
(
    input  wire logic                  ref_clk,        // 25 MHz clock
    input  wire logic                  sys_rst,        // Synchronous reset, high
    input  wire logic                  cmd_valid,      // Host command strobe
    input  wire sbes_pkg::sbes_cmd_t   cmd_op,         // Host command code
    input  wire logic [15:0]           cmd_data,       // Mask write data
    input  wire logic [15:0]           fail_set,       // Failure group events
    input  wire logic                  signal_quality_summary,  // Quality group
    input  wire logic                  operation_group_summary, // Operation group
    input  wire logic                  out_q_avail,    // Unread output present
    input  wire logic                  ops_busy,       // Operations pending
    input  wire logic                  q_read_empty,   // Read of empty queue
    input  wire logic                  q_data_lost,    // Output data lost
    input  wire logic                  device_error_event, // Internal error
    input  wire logic                  exec_err,       // Command not executable
    input  wire logic                  cmd_err,        // Malformed message
    input  wire logic                  pwr_on_evt,     // Power-up seen
    output logic                       srq_r,          // Service request line
    output logic [7:0]                 status_byte_r,  // Live status byte
    output logic                       resp_valid_r,   // Query answer strobe
    output logic [15:0]                resp_data_r     // Query answer data
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]  service_request_mask_r;
    logic [15:0] standard_event_mask_r;
    logic        opc_armed_r;
    logic        opc_done;
    logic [7:0]  core_sum;
    logic        mss_nxt;
    logic        esb;
    logic [7:0]  status_nxt;
    logic        rd_esr;
    logic        do_cls;
    logic [15:0] evt_set;

    sbes_latch_if #(.W(EVT_W)) evt_if ();
    sbes_latch_if #(.W(EVT_W)) fail_if ();

    // ----------------------------------------------------------------
    // Latches for standard events and failures
    // ----------------------------------------------------------------
    sbes_event_latch #(
        .W       (EVT_W),
        .USED    (EVT_USED),
        .RST_VAL (EVT_RST)
    ) u_evt (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .lat     (evt_if.store)
    );

    sbes_event_latch #(
        .W       (EVT_W),
        .USED    (16'hffff),
        .RST_VAL (FAIL_RST)
    ) u_fail (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .lat     (fail_if.store)
    );

    // Failures latch straight in and are never cleared
    assign fail_if.set = fail_set;
    assign fail_if.clr = '0;

    // ----------------------------------------------------------------
    // Standard event sources
    // ----------------------------------------------------------------
    assign rd_esr   = cmd_valid && (cmd_op == SBES_CMD_ESR_Q);
    assign do_cls   = cmd_valid && (cmd_op == SBES_CMD_CLS);
    assign opc_done = opc_armed_r && !ops_busy;

    // Every true source state is latched; no transition filter
    always_comb
    begin
        evt_set          = '0;
        evt_set[EVT_OPC] = opc_done;
        evt_set[EVT_QYE] = q_read_empty || q_data_lost;
        evt_set[EVT_DEV] = device_error_event;
        evt_set[EVT_EXE] = exec_err;
        evt_set[EVT_CME] = cmd_err;
        evt_set[EVT_PON] = pwr_on_evt;
    end

    // Event read or clear command empties the latch; unused bits held zero
    assign evt_if.set = evt_set;
    assign evt_if.clr = (rd_esr || do_cls) ? 16'hffff : 16'h0000;

    // ----------------------------------------------------------------
    // Operation-complete tracking
    // ----------------------------------------------------------------
    // Armed by the command, disarmed once it fires or on a clear command
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            opc_armed_r <= 1'b0;
        else if (cmd_valid && cmd_op == SBES_CMD_OPC)
            opc_armed_r <= 1'b1;
        else if (opc_done || do_cls)
            opc_armed_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Mask registers
    // ----------------------------------------------------------------
    // Request mask stores all 8 bits; bit 6 is dropped when summed
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            service_request_mask_r <= SRE_RST;
        else if (cmd_valid && cmd_op == SBES_CMD_SRE_W)
            service_request_mask_r <= cmd_data[7:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            standard_event_mask_r <= ESE_RST;
        else if (cmd_valid && cmd_op == SBES_CMD_ESE_W)
            standard_event_mask_r <= cmd_data;
    end

    // ----------------------------------------------------------------
    // Status byte and service request
    // ----------------------------------------------------------------
    assign esb = |(evt_if.q & standard_event_mask_r);

    always_comb
    begin
        core_sum           = 8'h00;
        core_sum[STB_FAIL] = |fail_if.q;
        core_sum[STB_QUAL] = signal_quality_summary;
        core_sum[STB_MAV]  = out_q_avail;
        core_sum[STB_ESB]  = esb;
        core_sum[STB_OPGR] = operation_group_summary;
    end

    // Enable bit 6 is masked off so the summary cannot feed itself
    assign mss_nxt = |(core_sum & service_request_mask_r & SRE_SUM_MASK);

    always_comb
    begin
        status_nxt          = core_sum;
        status_nxt[STB_RQS] = mss_nxt;
    end

    // Byte and line come from the same term, so poll and query agree
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            status_byte_r <= STB_RST;
            srq_r         <= 1'b0;
        end
        else
        begin
            status_byte_r <= status_nxt;
            srq_r         <= mss_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Query answers
    // ----------------------------------------------------------------
    // Reads of the byte never disturb it; only the event query clears
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            resp_valid_r <= 1'b0;
            resp_data_r  <= 16'h0000;
        end
        else
        begin
            resp_valid_r <= 1'b0;
            if (cmd_valid)
            begin
                case (cmd_op)
                    SBES_CMD_SPOLL, SBES_CMD_STB_Q:
                    begin
                        resp_valid_r <= 1'b1;
                        resp_data_r  <= {8'h00, status_byte_r};
                    end
                    SBES_CMD_SRE_Q:
                    begin
                        resp_valid_r <= 1'b1;
                        resp_data_r  <= {8'h00, service_request_mask_r};
                    end
                    SBES_CMD_ESE_Q:
                    begin
                        resp_valid_r <= 1'b1;
                        resp_data_r  <= standard_event_mask_r;
                    end
                    SBES_CMD_ESR_Q:
                    begin
                        resp_valid_r <= 1'b1;
                        resp_data_r  <= evt_if.q;
                    end
                    default:
                    begin
                        resp_valid_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_byte_read;
        cmd_valid && (cmd_op == SBES_CMD_SPOLL || cmd_op == SBES_CMD_STB_Q);
    endsequence

    sequence s_esr_read;
        cmd_valid && cmd_op == SBES_CMD_ESR_Q;
    endsequence

    property p_fail_sum;
        (|fail_if.q) |=> status_byte_r[STB_FAIL] [*3];
    endproperty
    a_fail_sum: assert property (p_fail_sum)
        else $error("failure summary bit not set");

    property p_fail_sticky;
        status_byte_r[STB_FAIL] |=> status_byte_r[STB_FAIL];
    endproperty
    a_fail_sticky: assert property (p_fail_sticky)
        else $error("failure summary bit dropped");

    property p_quality_sum;
        status_byte_r[STB_QUAL] == $past(signal_quality_summary)
            && status_byte_r[STB_OPGR] == $past(operation_group_summary);
    endproperty
    a_quality_sum: assert property (p_quality_sum)
        else $error("group summary bit wrong");

    property p_mav;
        out_q_avail |=> status_byte_r[STB_MAV];
    endproperty
    a_mav: assert property (p_mav)
        else $error("message available bit not held");

    property p_esb;
        (|(evt_if.q & standard_event_mask_r)) |=> status_byte_r[STB_ESB];
    endproperty
    a_esb: assert property (p_esb)
        else $error("event summary bit not set");

    property p_srq_line;
        srq_r == status_byte_r[STB_RQS];
    endproperty
    a_srq_line: assert property (p_srq_line)
        else $error("request line and bit 6 differ");

    property p_byte_read;
        s_byte_read |=> resp_valid_r && resp_data_r == {8'h00, $past(status_byte_r)};
    endproperty
    a_byte_read: assert property (p_byte_read)
        else $error("status byte answer wrong");

    property p_unused;
        status_byte_r[2:1] == 2'b00 && (evt_if.q & ~EVT_USED) == 16'h0000;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bit reads one");

    property p_esr_clear;
        s_esr_read |=> resp_data_r == $past(evt_if.q)
            && evt_if.q == ($past(evt_set) & EVT_USED);
    endproperty
    a_esr_clear: assert property (p_esr_clear)
        else $error("event query did not answer and clear");

    property p_mask_req;
        (|(status_byte_r & service_request_mask_r & SRE_SUM_MASK)) && $stable(service_request_mask_r) |-> srq_r;
    endproperty
    a_mask_req: assert property (p_mask_req)
        else $error("enabled summary raised no request");

    property p_opc;
        opc_armed_r && !ops_busy && !do_cls && !rd_esr |=> evt_if.q[EVT_OPC];
    endproperty
    a_opc: assert property (p_opc)
        else $error("operation complete not set");

endmodule

//--- hdl/sbes_pkg.sv
// Constants and types for the status byte and standard event summary block
package sbes_pkg;

    // ----------------------------------------------------------------
    // Status byte bit positions
    // ----------------------------------------------------------------
    localparam int STB_FAIL = 0;
    localparam int STB_QUAL = 3;
    localparam int STB_MAV  = 4;
    localparam int STB_ESB  = 5;
    localparam int STB_RQS  = 6;
    localparam int STB_OPGR = 7;
    localparam logic [7:0] STB_RST      = 8'h00;
    localparam logic [7:0] SRE_RST      = 8'h00;
    localparam logic [7:0] SRE_SUM_MASK = 8'hbf;  // Enable bit 6 never counts

    // ----------------------------------------------------------------
    // Standard event bit positions and masks
    // ----------------------------------------------------------------
    localparam int EVT_W   = 16;
    localparam int EVT_OPC = 0;
    localparam int EVT_QYE = 2;
    localparam int EVT_DEV = 3;
    localparam int EVT_EXE = 4;
    localparam int EVT_CME = 5;
    localparam int EVT_PON = 7;
    localparam logic [15:0] EVT_USED = 16'h00bd;  // Bits 1, 6, 8-15 read zero
    localparam logic [15:0] EVT_RST  = 16'h0080;  // Power-on event seen at start
    localparam logic [15:0] ESE_RST  = 16'h0000;
    localparam logic [15:0] FAIL_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Host command codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SBES_CMD_SPOLL = 4'h0,
        SBES_CMD_STB_Q = 4'h1,
        SBES_CMD_SRE_W = 4'h2,
        SBES_CMD_SRE_Q = 4'h3,
        SBES_CMD_ESE_W = 4'h4,
        SBES_CMD_ESE_Q = 4'h5,
        SBES_CMD_ESR_Q = 4'h6,
        SBES_CMD_CLS   = 4'h7,
        SBES_CMD_OPC   = 4'h8
    } sbes_cmd_t;

endpackage

//--- hdl/sbes_latch_if.sv
// Carrier between the summary logic and a sticky event latch
`timescale 1ns/1ps
interface sbes_latch_if #(parameter int W = 16);
    logic [W-1:0] set;  // Bits to latch this cycle
    logic [W-1:0] clr;  // Bits to clear this cycle
    logic [W-1:0] q;    // Latched value

    modport owner (output set, output clr, input q);
    modport store (input set, input clr, output q);
endinterface

//--- hdl/sbes_event_latch.sv
// Sticky event latch with set-over-clear priority
`timescale 1ns/1ps
module sbes_event_latch #(
    parameter int          W       = 16,
    parameter logic [15:0] USED    = 16'hffff,
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input  wire logic     ref_clk,  // 25 MHz clock
    input  wire logic     sys_rst,  // Synchronous reset, active high
    sbes_latch_if.store   lat       // Set, clear and latched value
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (W < 1 || W > 16)
    begin : g_chk
        $error("sbes_event_latch: W must be 1 to 16");
    end

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // A set in the same cycle as a clear wins, so no event is lost
    assign q_nxt = ((q_r & ~lat.clr) | lat.set) & USED[W-1:0];

    // Latch storage
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            q_r <= RST_VAL[W-1:0];
        else
            q_r <= q_nxt;
    end

    assign lat.q = q_r;

endmodule

//--- bench/sbes_host.sv
// Host controller model that issues commands and collects the answers
`timescale 1ns/1ps
module sbes_host (
    input  wire logic                ref_clk,       // Block clock
    output logic                     cmd_valid,     // Command strobe
    output sbes_pkg::sbes_cmd_t      cmd_op,        // Command code
    output logic [15:0]              cmd_data,      // Mask write data
    input  wire logic                resp_valid_r,  // Answer strobe
    input  wire logic [15:0]         resp_data_r    // Answer data
);
    import sbes_pkg::*;

    // Idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_op    = SBES_CMD_SPOLL;
        cmd_data  = 16'h0000;
    end

    // One command: optional idle gap, one-cycle strobe, answer sampled while it stands
    task automatic issue(input sbes_cmd_t op, input logic [15:0] d, input int gap,
                         output logic got, output logic [15:0] data);
        repeat (gap) @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_data  = d;
        @(negedge ref_clk);
        // The answer strobe lasts only the cycle after the taking edge, so take it now
        got  = resp_valid_r;
        data = resp_data_r;
        // Released data shows the inverse so a stale value is never mistaken
        cmd_valid = 1'b0;
        cmd_data  = ~d;
        @(negedge ref_clk);
    endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the status byte and standard event summary block
`timescale 1ns/1ps
module tb;
    import sbes_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                ref_clk       = 1'b0;
    logic                sys_rst       = 1'b1;
    logic [15:0]         fail_set      = 16'h0000;
    logic [2:0]          sums          = 3'h0;   // Quality, operation, queue
    logic                ops_busy      = 1'b0;
    logic [5:0]          src           = 6'h00;  // Event sources
    logic                cmd_valid;
    sbes_cmd_t           cmd_op;
    logic [15:0]         cmd_data;
    logic                srq_r;
    logic [7:0]          status_byte_r;
    logic                resp_valid_r;
    logic [15:0]         resp_data_r;
    int                  failures      = 0;
    int                  comparisons   = 0;
    logic [15:0]         exp_evt [6]   = '{16'h0004, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0080};

    // Free-running 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    sbes_top u_sbes_top (
        .ref_clk                 (ref_clk),
        .sys_rst                 (sys_rst),
        .cmd_valid               (cmd_valid),
        .cmd_op                  (cmd_op),
        .cmd_data                (cmd_data),
        .fail_set                (fail_set),
        .signal_quality_summary  (sums[0]),
        .operation_group_summary (sums[1]),
        .out_q_avail             (sums[2]),
        .ops_busy                (ops_busy),
        .q_read_empty            (src[0]),
        .q_data_lost             (src[1]),
        .device_error_event      (src[2]),
        .exec_err                (src[3]),
        .cmd_err                 (src[4]),
        .pwr_on_evt              (src[5]),
        .srq_r                   (srq_r),
        .status_byte_r           (status_byte_r),
        .resp_valid_r            (resp_valid_r),
        .resp_data_r             (resp_data_r)
    );

    sbes_host u_sbes_host (
        .ref_clk      (ref_clk),
        .cmd_valid    (cmd_valid),
        .cmd_op       (cmd_op),
        .cmd_data     (cmd_data),
        .resp_valid_r (resp_valid_r),
        .resp_data_r  (resp_data_r)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Query must answer in the cycle after the command with the expected word
    task automatic query(input sbes_cmd_t op, input logic [15:0] exp);
        logic        got;
        logic [15:0] d;
        u_sbes_host.issue(op, 16'h0000, 0, got, d);
        chk({15'h0000, got}, 16'h0001);
        chk(d, exp);
    endtask

    // Writes and plain commands give no answer; sent after an idle gap
    task automatic send(input sbes_cmd_t op, input logic [15:0] v);
        logic        got;
        logic [15:0] d;
        u_sbes_host.issue(op, v, 2, got, d);
        chk({15'h0000, got}, 16'h0000);
    endtask

    task automatic stb(input logic [7:0] b, input logic s);
        chk({8'h00, status_byte_r}, {8'h00, b});
        chk({15'h0000, srq_r}, {15'h0000, s});
    endtask

    task automatic pulse(input int i);
        src[i] = 1'b1;
        cyc(1);
        src[i] = 1'b0;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        stb(8'h00, 1'b0);
        query(SBES_CMD_ESR_Q, 16'h0080);
        query(SBES_CMD_ESR_Q, 16'h0000);
        query(SBES_CMD_SRE_Q, 16'h0000);
        query(SBES_CMD_ESE_Q, 16'h0000);
    endtask

    task automatic t_summary;
        sums = 3'h7;
        cyc(2);
        stb(8'h98, 1'b0);
        query(SBES_CMD_SPOLL, 16'h0098);
        query(SBES_CMD_STB_Q, 16'h0098);
        send(SBES_CMD_SRE_W, 16'h0088);
        cyc(1);
        stb(8'hd8, 1'b1);
        query(SBES_CMD_SPOLL, 16'h00d8);
        query(SBES_CMD_STB_Q, 16'h00d8);
        query(SBES_CMD_STB_Q, 16'h00d8);
        sums = 3'h3;
        cyc(2);
        stb(8'hc8, 1'b1);
        // Only enable bit 6 set: an active summary must not raise a request
        send(SBES_CMD_SRE_W, 16'hff40);
        sums = 3'h1;
        cyc(2);
        stb(8'h08, 1'b0);
        query(SBES_CMD_SRE_Q, 16'h0040);
        sums = 3'h0;
    endtask

    task automatic t_events;
        send(SBES_CMD_ESE_W, 16'hffff);
        query(SBES_CMD_ESE_Q, 16'hffff);
        // Each source latches its bit, the two queue sources both bit 2; reading clears it again
        for (int i = 0; i < 6; i++)
        begin
            pulse(i);
            cyc(1);
            stb(8'h20, 1'b0);
            query(SBES_CMD_ESR_Q, exp_evt[i]);
            stb(8'h00, 1'b0);
        end
        send(SBES_CMD_ESE_W, 16'h0010);
        pulse(2);
        cyc(1);
        stb(8'h00, 1'b0);
        query(SBES_CMD_ESR_Q, 16'h0008);
        send(SBES_CMD_ESE_W, 16'h0020);
        send(SBES_CMD_SRE_W, 16'h0020);
        pulse(4);
        cyc(1);
        stb(8'h60, 1'b1);
        send(SBES_CMD_CLS, 16'h0000);
        cyc(1);
        stb(8'h00, 1'b0);
        query(SBES_CMD_ESR_Q, 16'h0000);
    endtask

    task automatic t_opc;
        send(SBES_CMD_ESE_W, 16'h0001);
        ops_busy = 1'b1;
        send(SBES_CMD_OPC, 16'h0000);
        cyc(4);
        stb(8'h00, 1'b0);
        ops_busy = 1'b0;
        cyc(3);
        stb(8'h60, 1'b1);
        query(SBES_CMD_ESR_Q, 16'h0001);
    endtask

    task automatic t_fail;
        send(SBES_CMD_SRE_W, 16'h0001);
        fail_set = 16'h0400;
        cyc(1);
        fail_set = 16'h0000;
        cyc(1);
        stb(8'h41, 1'b1);
        send(SBES_CMD_CLS, 16'h0000);
        cyc(2);
        stb(8'h41, 1'b1);
        // Unknown code must stay silent
        send(sbes_cmd_t'(4'h9), 16'h0000);
    endtask

    // Main sequence: reset for three cycles, then every scenario
    initial
    begin
        cyc(3);
        sys_rst = 1'b0;
        t_reset();
        t_summary();
        t_events();
        t_opc();
        t_fail();
        report_and_stop();
    end

    // Watchdog well beyond the roughly 160 cycles the run needs
    initial
    begin
        #160000;
        failures++;
        report_and_stop();
    end
endmodule
